// ### pgen_defs.vh
`ifndef PGEN_DEFS_VH
`define PGEN_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PG_ADDR_W 12
`define PG_ADDR_CNT_HI 12'h0fb0
`define PG_ADDR_CNT_LO 12'h0fb1
`define PG_ADDR_PER_HI 12'h0fb2
`define PG_ADDR_PER_LO 12'h0fb3
`define PG_ADDR_DUTY_HI 12'h0fb4
`define PG_ADDR_DUTY_LO 12'h0fb5

// ----------------------------------------------------------------
// reset values and fixed constants
// ----------------------------------------------------------------
`define PG_BUF_RST 8'hff
`define PG_BYTE_ZERO 8'h00
`define PG_CNT_RST 16'h0000
`define PG_CNT_ZERO 16'h0000
`define PG_CNT_LAST 16'h0001
`define PG_CNT_STEP 16'h0001
`define PG_DATA_ZERO 16'h0000

`endif

// ### byte_pair_buffer.v
`include "pgen_defs.vh"

// two-byte setting buffer with upper-first commit
module byte_pair_buffer #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire arst_n,
    input wire wr_hi,
    input wire wr_lo,
    input wire wr_word,
    input wire [2*WIDTH-1:0] wdata,
    output reg [WIDTH-1:0] read_hi,
    output reg [WIDTH-1:0] read_lo,
    output wire [2*WIDTH-1:0] value,
    output reg pending
);

    reg [WIDTH-1:0] valid_hi;

    // ----------------------------------------------------------------
    // byte and word writes
    // ----------------------------------------------------------------
    // the upper byte only commits with the lower one, so a load in
    // between still sees the last complete pair
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            read_hi <= `PG_BUF_RST;
            read_lo <= `PG_BUF_RST;
            valid_hi <= `PG_BUF_RST;
            pending <= 1'b0;
        end else if (wr_word) begin
            read_hi <= wdata[2*WIDTH-1:WIDTH];
            read_lo <= wdata[WIDTH-1:0];
            valid_hi <= wdata[2*WIDTH-1:WIDTH];
            pending <= 1'b0;
        end else if (wr_hi) begin
            read_hi <= wdata[WIDTH-1:0];
            pending <= 1'b1;
        end else if (wr_lo) begin
            read_lo <= wdata[WIDTH-1:0];
            valid_hi <= read_hi;
            pending <= 1'b0;
        end
    end

    // value seen by a load: last committed upper with current lower
    assign value = {valid_hi, read_lo};

endmodule // byte_pair_buffer

// ### pulse_level.v
`include "pgen_defs.vh"

// registered output level from counter and working duty
module pulse_level #(
    parameter CNT_W = 16
) (
    input wire clk,
    input wire arst_n,
    input wire running,
    input wire polarity_select,
    input wire [CNT_W-1:0] counter,
    input wire [CNT_W-1:0] duty,
    input wire [CNT_W-1:0] period,
    output reg level_out
);

    reg next_level;

    // ----------------------------------------------------------------
    // level decision
    // ----------------------------------------------------------------
    // counter walks period..1, so counter <= duty gives duty ticks high
    always @* begin
        next_level = 1'b0;
        if (!running) begin
            next_level = 1'b0;
        end else if (duty == `PG_CNT_ZERO) begin
            next_level = 1'b0;
        end else if (duty > period) begin
            next_level = 1'b0;
        end else if (duty == period) begin
            next_level = 1'b1;
        end else begin
            next_level = (counter <= duty);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level_out <= 1'b0;
        end else begin
            level_out <= next_level ^ polarity_select;
        end
    end

endmodule // pulse_level

// ### pulse_gen_period_duty_regs.v
// The address-and-strobe port was chosen for this implementation.
`include "pgen_defs.vh"

module pulse_gen_period_duty_regs #(
    parameter CNT_W = 16,
    parameter BYTE_W = 8
) (
    input wire clk,
    input wire arst_n,
    input wire [`PG_ADDR_W-1:0] addr,
    input wire [CNT_W-1:0] wdata,
    input wire wr,
    input wire rd,
    input wire word_access,
    input wire count_tick,
    input wire run,
    input wire start,
    input wire polarity_select,
    output reg [CNT_W-1:0] rdata,
    output reg running,
    output wire pulse_output_pin
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [CNT_W-1:0] counter;
    reg [CNT_W-1:0] work_duty;
    reg [CNT_W-1:0] work_period;
    reg [BYTE_W-1:0] count_readback_low;
    reg [CNT_W-1:0] next_rdata;
    wire [BYTE_W-1:0] period_buffer_high;
    wire [BYTE_W-1:0] period_buffer_low;
    wire [BYTE_W-1:0] duty_buffer_high;
    wire [BYTE_W-1:0] duty_buffer_low;
    wire [CNT_W-1:0] period_value;
    wire [CNT_W-1:0] duty_value;
    wire duty_pending;
    wire hit_cnt_hi;
    wire hit_cnt_lo;
    wire hit_per_hi;
    wire hit_per_lo;
    wire hit_duty_hi;
    wire hit_duty_lo;
    wire load;
    wire start_load;
    wire tick_load;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one compare per byte address; word writes are decoded at upper only, word reads at both
    assign hit_cnt_hi = (addr == `PG_ADDR_CNT_HI);
    assign hit_cnt_lo = (addr == `PG_ADDR_CNT_LO);
    assign hit_per_hi = (addr == `PG_ADDR_PER_HI);
    assign hit_per_lo = (addr == `PG_ADDR_PER_LO);
    assign hit_duty_hi = (addr == `PG_ADDR_DUTY_HI);
    assign hit_duty_lo = (addr == `PG_ADDR_DUTY_LO);

    // ----------------------------------------------------------------
    // setting buffers
    // ----------------------------------------------------------------
    // period buffer; the pair only reaches the counter at a load
    byte_pair_buffer #(
        .WIDTH(BYTE_W)
    ) u_period_buffer (
        .clk(clk),
        .arst_n(arst_n),
        .wr_hi(wr && !word_access && hit_per_hi),
        .wr_lo(wr && !word_access && hit_per_lo),
        .wr_word(wr && word_access && hit_per_hi),
        .wdata(wdata),
        .read_hi(period_buffer_high),
        .read_lo(period_buffer_low),
        .value(period_value),
        .pending()
    );

    // duty buffer; its pending flag gates the transfer
    byte_pair_buffer #(
        .WIDTH(BYTE_W)
    ) u_duty_buffer (
        .clk(clk),
        .arst_n(arst_n),
        .wr_hi(wr && !word_access && hit_duty_hi),
        .wr_lo(wr && !word_access && hit_duty_lo),
        .wr_word(wr && word_access && hit_duty_hi),
        .wdata(wdata),
        .read_hi(duty_buffer_high),
        .read_lo(duty_buffer_low),
        .value(duty_value),
        .pending(duty_pending)
    );

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    // stopping halts at once; a start while enabled loads and runs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            running <= 1'b0;
        end else if (!run) begin
            running <= 1'b0;
        end else if (start) begin
            running <= 1'b1;
        end
    end

    // a start or the end of a period both count as a load
    assign start_load = run && start;
    assign tick_load = run && running && count_tick && (counter <= `PG_CNT_LAST);
    assign load = start_load || tick_load;

    // ----------------------------------------------------------------
    // down-counter
    // ----------------------------------------------------------------
    // the counter keeps its value when stopped so it can still be read
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter <= `PG_CNT_RST;
            work_period <= `PG_CNT_RST;
        end else if (load) begin
            counter <= period_value;
            work_period <= period_value;
        end else if (run && running && count_tick) begin
            counter <= counter - `PG_CNT_STEP;
        end
    end

    // ----------------------------------------------------------------
    // working duty register
    // ----------------------------------------------------------------
    // reset to the buffer's reset pair so a first load is consistent
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            work_duty <= {`PG_BUF_RST, `PG_BUF_RST};
        end else if (load && !duty_pending) begin
            work_duty <= duty_value;
        end
        // pending skips transfer: no else, old duty kept
    end

    // ----------------------------------------------------------------
    // readback latch
    // ----------------------------------------------------------------
    // a byte read of the upper half freezes the lower half, so two byte
    // reads give one coherent count even while the counter moves
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_readback_low <= `PG_BYTE_ZERO;
        end else if (rd && !word_access && hit_cnt_hi) begin
            count_readback_low <= counter[BYTE_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // writes to the readback addresses decode to nothing; unmapped reads 0
    always @* begin
        next_rdata = `PG_DATA_ZERO;
        if (rd) begin
            if (word_access) begin
                if (hit_cnt_hi) begin
                    next_rdata = counter;
                end else if (hit_per_hi) begin
                    next_rdata = {period_buffer_high, period_buffer_low};
                end else if (hit_duty_hi) begin
                    next_rdata = {duty_buffer_high, duty_buffer_low};
                end else if (hit_cnt_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, count_readback_low};
                end else if (hit_per_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, period_buffer_low};
                end else if (hit_duty_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, duty_buffer_low};
                end
            end else begin
                if (hit_cnt_hi) begin
                    next_rdata = {`PG_BYTE_ZERO, counter[CNT_W-1:BYTE_W]};
                end else if (hit_cnt_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, count_readback_low};
                end else if (hit_per_hi) begin
                    next_rdata = {`PG_BYTE_ZERO, period_buffer_high};
                end else if (hit_per_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, period_buffer_low};
                end else if (hit_duty_hi) begin
                    next_rdata = {`PG_BYTE_ZERO, duty_buffer_high};
                end else if (hit_duty_lo) begin
                    next_rdata = {`PG_BYTE_ZERO, duty_buffer_low};
                end
            end
        end
    end

    // read data stand for one cycle only, zero otherwise
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= `PG_DATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // output waveform
    // ----------------------------------------------------------------
    // forbidden periods not checked; software must avoid them
    pulse_level #(
        .CNT_W(CNT_W)
    ) u_pulse_level (
        .clk(clk),
        .arst_n(arst_n),
        .running(running),
        .polarity_select(polarity_select),
        .counter(counter),
        .duty(work_duty),
        .period(work_period),
        .level_out(pulse_output_pin)
    );

endmodule // pulse_gen_period_duty_regs

// ### pgen_checker_asserts.sv
`include "pgen_defs.vh"

module pgen_checker #(
    parameter CNT_W = 16,
    parameter BYTE_W = 8
) (
    input wire clk,
    input wire arst_n,
    input wire [`PG_ADDR_W-1:0] addr,
    input wire [CNT_W-1:0] wdata,
    input wire wr,
    input wire rd,
    input wire word_access,
    input wire run,
    input wire start,
    input wire polarity_select,
    input wire [CNT_W-1:0] rdata,
    input wire running,
    input wire pulse_output_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------------------------------
    // bus steps
    // ----------------------------------------------------------------
    sequence rd_at(a, w);
        rd && word_access == w && addr == a;
    endsequence
    sequence wr_at(a, w);
        wr && word_access == w && addr == a;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero");
    per_word_a: assert property (wr_at(`PG_ADDR_PER_HI, 1'b1) ##1
        rd_at(`PG_ADDR_PER_HI, 1'b1) |=> rdata == $past(wdata, 2))
        else $error("period word lost");
    duty_word_a: assert property (wr_at(`PG_ADDR_DUTY_HI, 1'b1) ##1
        rd_at(`PG_ADDR_DUTY_HI, 1'b1) |=> rdata == $past(wdata, 2))
        else $error("duty word lost");
    // a write between two reads must not move the latch
    ro_latch_a: assert property (rd_at(`PG_ADDR_CNT_LO, 1'b0) ##1 !rd ##1
        wr_at(`PG_ADDR_CNT_LO, 1'b0) ##1 rd_at(`PG_ADDR_CNT_LO, 1'b0)
        |=> rdata == $past(rdata, 3))
        else $error("readback latch written");
    count_hold_a: assert property (((!running && !start) and
        rd_at(`PG_ADDR_CNT_HI, 1'b1)) ##1 !start ##1 (!start and rd_at(`PG_ADDR_CNT_HI, 1'b1))
        |=> rdata == $past(rdata, 2))
        else $error("counter moved while stopped");
    start_run_a: assert property (run && start |=> running)
        else $error("start did not run");
    stop_run_a: assert property (!run |=> !running)
        else $error("stop did not halt");
    idle_pin_a: assert property (!running |=> pulse_output_pin == $past(polarity_select))
        else $error("idle level wrong");
endmodule // pgen_checker

bind pulse_gen_period_duty_regs pgen_checker #(.CNT_W(CNT_W), .BYTE_W(BYTE_W)) chk_u (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .word_access(word_access), .run(run), .start(start), .polarity_select(polarity_select),
    .rdata(rdata), .running(running), .pulse_output_pin(pulse_output_pin));

// ### pulse_load.sv
module pulse_load (
    input wire clk,
    input wire arst_n,
    input wire pulse_output_pin,
    input wire meas_en,
    output logic [15:0] high_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_d;

    // high-cycle tally, restarts at each window so no clear pin is needed
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_cnt <= 16'h0000;
            en_d <= 1'b0;
        end else begin
            en_d <= meas_en;
            if (meas_en) begin
                high_cnt <= (en_d ? high_cnt : 16'h0000) + {15'h0000, pulse_output_pin};
            end
        end
    end
endmodule // pulse_load

// ### pulse_gen_period_duty_regs_tb.sv
`include "pgen_defs.vh"

module pulse_gen_period_duty_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] addr = 12'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic word_access = 1'b0;
    logic count_tick = 1'b0;
    logic run = 1'b0;
    logic start = 1'b0;
    logic polarity_select = 1'b0;
    logic meas_en = 1'b0;
    wire [15:0] rdata;
    wire running;
    wire pulse_output_pin;
    wire [15:0] high_cnt;
    int error_cnt = 0;
    int checks_done = 0;

    // 250 MHz
    always #2 clk = ~clk;

    pulse_gen_period_duty_regs dut_u (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .word_access(word_access), .count_tick(count_tick), .run(run),
        .start(start), .polarity_select(polarity_select), .rdata(rdata), .running(running),
        .pulse_output_pin(pulse_output_pin));
    pulse_load load_u (.clk(clk), .arst_n(arst_n), .pulse_output_pin(pulse_output_pin),
        .meas_en(meas_en), .high_cnt(high_cnt));

    // ----------------------------------------------------------------
    // bus and timer helpers
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic w, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        word_access <= w;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic w, input logic [15:0] e,
            input string n);
        rd <= 1'b1;
        addr <= a;
        word_access <= w;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, e, rdata);
        @(posedge clk);
    endtask
    task automatic kick;
        start <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic ticks(input int n);
        count_tick <= 1'b1;
        repeat (n) @(posedge clk);
        count_tick <= 1'b0;
    endtask
    // 34 cycles of steady ticking, high cycles tallied over the last 32, two periods of 16
    task automatic meas(input logic [15:0] e);
        count_tick <= 1'b1;
        repeat (2) @(posedge clk);
        meas_en <= 1'b1;
        repeat (32) @(posedge clk);
        meas_en <= 1'b0;
        count_tick <= 1'b0;
        @(posedge clk);
        chk("high cycles", e, high_cnt);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            rd_chk(12'(`PG_ADDR_CNT_HI + i), 1'b0, (i < 2) ? 16'h0000 : 16'h00ff, "reset");
        end
        rd_chk(12'h0fb6, 1'b0, 16'h0000, "unmapped");
        rd_chk(`PG_ADDR_CNT_LO, 1'b0, 16'h0000, "latch");
        wr_reg(`PG_ADDR_CNT_LO, 1'b0, 16'h00a5);
        rd_chk(`PG_ADDR_CNT_LO, 1'b0, 16'h0000, "latch");
        wr_reg(`PG_ADDR_CNT_HI, 1'b1, 16'ha5a5);
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0000, "counter");
        // period 0010 keeps clear of the two forbidden values
        wr_reg(`PG_ADDR_PER_HI, 1'b1, 16'h0010);
        rd_chk(`PG_ADDR_PER_HI, 1'b1, 16'h0010, "period word");
        rd_chk(`PG_ADDR_PER_LO, 1'b0, 16'h0010, "period low");
        wr_reg(`PG_ADDR_DUTY_HI, 1'b1, 16'h0004);
        rd_chk(`PG_ADDR_DUTY_HI, 1'b1, 16'h0004, "duty word");
    endtask
    task automatic t_count;
        kick();
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0010, "loaded");
        chk("running", 16'h0001, {15'h0000, running});
        ticks(3);
        rd_chk(`PG_ADDR_CNT_HI, 1'b0, 16'h0000, "count high");
        rd_chk(`PG_ADDR_CNT_LO, 1'b0, 16'h000d, "count low");
        ticks(2);
        rd_chk(`PG_ADDR_CNT_LO, 1'b0, 16'h000d, "stale low");
        meas(16'h0008);
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0009, "after 34 ticks");
        wr_reg(`PG_ADDR_PER_HI, 1'b1, 16'h0020);
        ticks(1);
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0008, "no early load");
        ticks(8);
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0020, "new period");
        run <= 1'b0;
        count_tick <= 1'b1;
        repeat (3) @(posedge clk);
        chk("stopped", 16'h0000, {15'h0000, running});
        chk("idle low", 16'h0000, {15'h0000, pulse_output_pin});
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0020, "held");
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0020, "held");
        count_tick <= 1'b0;
        polarity_select <= 1'b1;
        repeat (2) @(posedge clk);
        chk("idle high", 16'h0001, {15'h0000, pulse_output_pin});
        polarity_select <= 1'b0;
    endtask
    // half-written pairs around a load
    task automatic t_pairs;
        wr_reg(`PG_ADDR_PER_HI, 1'b0, 16'h0001);
        kick();
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0020, "old pair");
        wr_reg(`PG_ADDR_PER_LO, 1'b0, 16'h0040);
        kick();
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0140, "new pair");
        wr_reg(`PG_ADDR_PER_LO, 1'b0, 16'h0010);
        kick();
        rd_chk(`PG_ADDR_CNT_HI, 1'b1, 16'h0110, "lone low");
        // a free edge between writes, so wr is never driven twice in one step
        wr_reg(`PG_ADDR_PER_HI, 1'b1, 16'h0010);
        @(posedge clk);
        wr_reg(`PG_ADDR_DUTY_HI, 1'b0, 16'h0000);
        @(posedge clk);
        wr_reg(`PG_ADDR_DUTY_LO, 1'b0, 16'h0006);
        kick();
        meas(16'h000c);
        wr_reg(`PG_ADDR_DUTY_HI, 1'b0, 16'h0001);
        kick();
        meas(16'h000c);
        wr_reg(`PG_ADDR_DUTY_LO, 1'b0, 16'h0006);
        kick();
        meas(16'h0000);
    endtask
    // duty equal to, zero and above the period, both polarities
    task automatic t_edge;
        logic [15:0] d [3] = '{16'h0010, 16'h0000, 16'h0011};
        for (int i = 0; i < 6; i++) begin
            polarity_select <= i[0];
            wr_reg(`PG_ADDR_DUTY_HI, 1'b1, d[i/2]);
            kick();
            meas(((i < 2) ^ i[0]) ? 16'h0020 : 16'h0000);
        end
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_count();
        t_pairs();
        t_edge();
        final_report();
    end
    // hang guard, tests need about 460 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule // pulse_gen_period_duty_regs_tb
